/* File: verilog/cse_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Five 32-bit socket registers per function, mapped in memory space.
// - Event 00h, mask 04h, state 08h, force 0Ch, setup 10h; 14h-1Ch reserved.
// - Each function decodes against its own base address.
// - Extra power-saving register at 20h, cleared only by global reset.
// - Context bits survive host bus reset while power events are enabled.
// - Writing 1 clears an event bit; writing 0 leaves it.
// - Writing 1 to the injector sets the matching event bit.
// - Host bus reset clears all event bits, subject to retention.
// - Leaving card reset re-sets events if status or detect still true.
// - Unmasked set event raises the status-change interrupt while enabled.
// - Event bits 31 to 4 read as zero.
// - Event bit 3 sets when the power cycle state changes.
// - Event bit 2 sets when detect two state changes.
// - Event bit 1 sets when detect one state changes.
// - CardBus card: event bit 0 sets on rising status-change edge only.
// - 16-bit card: event bit 0 sets on both status-change edges.
// - Mask gates only the interrupt; events still set.
// - Detect gate enables interrupts only at 11; 00 off, others reserved.
module cse_regs
  import cse_pkg::*;
(
  // Clock, enable and resets
  input  wire logic               CLK_SYS_I,
  input  wire logic               RESET_N_I,
  input  wire logic               CE_I,
  input  wire logic               HOST_BUS_RESET_N_I,
  // Power management and interrupt control
  input  wire logic               PME_ENABLE_I,
  input  wire logic               IRQ_ENABLE_I,
  // Card type and card reset
  input  wire logic               CARDBUS_CARD_I,
  input  wire logic               CARD_RESET_I,
  // Host memory access
  input  wire logic [cse_pkg::CSE_AW-1:0]   BASE_ADDR_I,
  input  wire logic                         MEM_SEL_I,
  input  wire logic                         MEM_WR_I,
  input  wire logic [cse_pkg::CSE_AW-1:0]   MEM_ADDR_I,
  input  wire logic [cse_pkg::CSE_BE_W-1:0] MEM_BE_I,
  input  wire logic [cse_pkg::CSE_DW-1:0]   MEM_WDATA_I,
  output var  logic [cse_pkg::CSE_DW-1:0]   MEM_RDATA_O,
  output var  logic                         MEM_ACK_O,
  // Socket pins
  input  wire logic               CARD_STS_CHG_PIN_I,
  input  wire logic               DETECT_ONE_PIN_I,
  input  wire logic               DETECT_TWO_PIN_I,
  input  wire logic               POWER_CYCLE_PIN_I,
  // Status-change interrupt
  output var  logic               CSC_IRQ_O
);
  import cse_pkg::*;

  // ****************************************************************
  // Offset decode
  // ****************************************************************
  function automatic logic reg_hit(input cse_ofs_t ofs, input cse_ofs_t tgt);
    reg_hit = (ofs[CSE_OFS_W-1:2] == tgt[CSE_OFS_W-1:2]);
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  cse_ev_t   change_flags_q;
  cse_ev_t   change_flags_d;
  cse_ev_t   irq_gate_q;
  cse_ev_t   irq_gate_d;
  cse_word_t setup_q;
  cse_word_t setup_d;
  cse_word_t power_q;
  cse_word_t power_d;
  cse_word_t rdata_q;
  logic      ack_q;
  logic      irq_q;
  logic      card_reset_q;

  cse_ev_t   pins;
  cse_ev_t   hw_set;
  cse_ev_t   force_set;
  cse_ev_t   sw_clear;
  cse_ev_t   rearm_set;
  cse_ev_t   gate_eff;
  cse_ev_t   live;
  logic      base_hit;
  logic      wr_acc;
  logic      rd_acc;
  cse_ofs_t  ofs;
  logic      hit_event;
  logic      hit_mask;
  logic      hit_state;
  logic      hit_force;
  logic      hit_setup;
  logic      hit_power;
  logic      ctx_clear;
  logic      card_leave_reset;
  logic      sts_change;
  logic      irq_d;
  cse_word_t state_word;
  cse_word_t rd_word;
  cse_word_t wr_bits;
  cse_word_t byte_mask;

  cse_pin_if pin_if ();

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  assign pins[CSE_BIT_CARD_STS] = CARD_STS_CHG_PIN_I;
  assign pins[CSE_BIT_DET_ONE]  = DETECT_ONE_PIN_I;
  assign pins[CSE_BIT_DET_TWO]  = DETECT_TWO_PIN_I;
  assign pins[CSE_BIT_PWR_CYC]  = POWER_CYCLE_PIN_I;

  cse_pin_watch u_pin_watch (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESET_N_I),
    .ce_i    (CE_I),
    .pins_i  (pins),
    .pin_if  (pin_if.watch)
  );

  assign live = pin_if.level;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Window above the offset field must match this function's base
  assign base_hit = MEM_SEL_I &
    (MEM_ADDR_I[CSE_AW-1:CSE_OFS_W] == BASE_ADDR_I[CSE_AW-1:CSE_OFS_W]);
  assign ofs      = MEM_ADDR_I[CSE_OFS_W-1:0];
  assign wr_acc   = CE_I & base_hit & MEM_WR_I;
  assign rd_acc   = CE_I & base_hit & ~MEM_WR_I;

  assign hit_event = reg_hit(ofs, CSE_OFS_EVENT);
  assign hit_mask  = reg_hit(ofs, CSE_OFS_MASK);
  assign hit_state = reg_hit(ofs, CSE_OFS_STATE);
  assign hit_force = reg_hit(ofs, CSE_OFS_FORCE);
  assign hit_setup = reg_hit(ofs, CSE_OFS_SETUP);
  assign hit_power = reg_hit(ofs, CSE_OFS_POWER);

  // Byte lanes expanded to a bit mask
  genvar b;
  generate
    for (b = 0; b < CSE_BE_W; b++)
    begin : g_lane
      assign byte_mask[b*8 +: 8] = {8{MEM_BE_I[b]}};
    end
  endgenerate

  assign wr_bits = MEM_WDATA_I & byte_mask;

  // ****************************************************************
  // Event sources
  // ****************************************************************
  // Status change: rising only for CardBus, both edges for 16-bit
  assign sts_change = CARDBUS_CARD_I ?
    pin_if.rise[CSE_BIT_CARD_STS] :
    (pin_if.rise[CSE_BIT_CARD_STS] | pin_if.fall[CSE_BIT_CARD_STS]);

  assign card_leave_reset = CE_I & card_reset_q & ~CARD_RESET_I;

  // Status or detect still high on leaving card reset raises those events again
  assign rearm_set[CSE_BIT_CARD_STS] =
    card_leave_reset & live[CSE_BIT_CARD_STS];
  assign rearm_set[CSE_BIT_DET_ONE]  =
    card_leave_reset & live[CSE_BIT_DET_ONE];
  assign rearm_set[CSE_BIT_DET_TWO]  =
    card_leave_reset & live[CSE_BIT_DET_TWO];
  assign rearm_set[CSE_BIT_PWR_CYC]  = 1'b0;

  assign hw_set[CSE_BIT_CARD_STS] = sts_change;
  assign hw_set[CSE_BIT_DET_ONE]  =
    pin_if.rise[CSE_BIT_DET_ONE] | pin_if.fall[CSE_BIT_DET_ONE];
  assign hw_set[CSE_BIT_DET_TWO]  =
    pin_if.rise[CSE_BIT_DET_TWO] | pin_if.fall[CSE_BIT_DET_TWO];
  assign hw_set[CSE_BIT_PWR_CYC]  =
    pin_if.rise[CSE_BIT_PWR_CYC] | pin_if.fall[CSE_BIT_PWR_CYC];

  assign force_set = (wr_acc & hit_force) ?
    wr_bits[CSE_EV_W-1:0] : CSE_EVENT_RST;
  assign sw_clear  = (wr_acc & hit_event) ?
    wr_bits[CSE_EV_W-1:0] : CSE_EVENT_RST;

  // ****************************************************************
  // Context clearing
  // ****************************************************************
  // Host bus reset clears context only while power events are off
  assign ctx_clear = ~HOST_BUS_RESET_N_I & ~PME_ENABLE_I;

  // ****************************************************************
  // Next values
  // ****************************************************************
  assign change_flags_d = ctx_clear ? CSE_EVENT_RST :
    ((change_flags_q & ~sw_clear) | hw_set | rearm_set | force_set);

  assign irq_gate_d = ctx_clear ? CSE_MASK_RST :
    ((wr_acc & hit_mask) ?
      ((irq_gate_q & ~byte_mask[CSE_EV_W-1:0]) |
       wr_bits[CSE_EV_W-1:0]) :
      irq_gate_q);

  assign setup_d = ctx_clear ? CSE_SETUP_RST :
    ((wr_acc & hit_setup) ? ((setup_q & ~byte_mask) | wr_bits) : setup_q);

  // Global reset only, host bus reset has no effect here
  assign power_d = (wr_acc & hit_power) ?
    ((power_q & ~byte_mask) | wr_bits) : power_q;

  // ****************************************************************
  // Interrupt gating
  // ****************************************************************
  assign gate_eff[CSE_BIT_CARD_STS] = irq_gate_q[CSE_BIT_CARD_STS];
  assign gate_eff[CSE_BIT_PWR_CYC]  = irq_gate_q[CSE_BIT_PWR_CYC];
  // Detect pair passes only at the fully enabled code
  assign gate_eff[CSE_BIT_DET_ONE]  =
    (irq_gate_q[CSE_BIT_DET_TWO:CSE_BIT_DET_ONE] == CSE_GATE_ON);
  assign gate_eff[CSE_BIT_DET_TWO]  = gate_eff[CSE_BIT_DET_ONE];

  // Gate acts on the output only, flags update regardless
  assign irq_d = IRQ_ENABLE_I & |(change_flags_q & gate_eff);

  // ****************************************************************
  // Read data
  // ****************************************************************
  assign state_word = CSE_STATE_FIX | {{(CSE_DW-CSE_EV_W){1'b0}}, live};

  // Reserved offsets and holes read as zero
  assign rd_word =
    hit_event ? {{(CSE_DW-CSE_EV_W){1'b0}}, change_flags_q} :
    hit_mask  ? {{(CSE_DW-CSE_EV_W){1'b0}}, irq_gate_q} :
    hit_state ? state_word :
    hit_setup ? setup_q :
    hit_power ? power_q :
    32'h0000_0000;

  // ****************************************************************
  // Event and mask storage
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      change_flags_q <= CSE_EVENT_RST;
      irq_gate_q     <= CSE_MASK_RST;
    end
    else if (CE_I)
    begin
      change_flags_q <= change_flags_d;
      irq_gate_q     <= irq_gate_d;
    end
  end

  // ****************************************************************
  // Setup and power-saving storage
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      setup_q <= CSE_SETUP_RST;
      power_q <= CSE_POWER_RST;
    end
    else if (CE_I)
    begin
      setup_q <= setup_d;
      power_q <= power_d;
    end
  end

  // ****************************************************************
  // Card reset tracking
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      card_reset_q <= 1'b0;
    end
    else if (CE_I)
    begin
      card_reset_q <= CARD_RESET_I;
    end
  end

  // ****************************************************************
  // Bus answer and interrupt output
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rdata_q <= 32'h0000_0000;
      ack_q   <= 1'b0;
      irq_q   <= 1'b0;
    end
    else if (CE_I)
    begin
      ack_q   <= base_hit;
      rdata_q <= rd_acc ? rd_word : 32'h0000_0000;
      irq_q   <= irq_d;
    end
  end

  assign MEM_RDATA_O = rdata_q;
  assign MEM_ACK_O   = ack_q;
  assign CSC_IRQ_O   = irq_q;

endmodule
`default_nettype wire

/* File: verilog/cse_pkg.sv */
`default_nettype none
package cse_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned CSE_DW         = 32;
  localparam int unsigned CSE_AW         = 32;
  localparam int unsigned CSE_BE_W       = 4;
  localparam int unsigned CSE_EV_W       = 4;
  localparam int unsigned CSE_OFS_W      = 12;
  localparam int unsigned CSE_SYNC_DEPTH = 2;

  typedef logic [CSE_EV_W-1:0]  cse_ev_t;
  typedef logic [CSE_OFS_W-1:0] cse_ofs_t;
  typedef logic [CSE_DW-1:0]    cse_word_t;

  // ****************************************************************
  // Register offsets from the socket base address
  // ****************************************************************
  localparam cse_ofs_t CSE_OFS_EVENT = 12'h000;
  localparam cse_ofs_t CSE_OFS_MASK  = 12'h004;
  localparam cse_ofs_t CSE_OFS_STATE = 12'h008;
  localparam cse_ofs_t CSE_OFS_FORCE = 12'h00c;
  localparam cse_ofs_t CSE_OFS_SETUP = 12'h010;
  localparam cse_ofs_t CSE_OFS_POWER = 12'h020;

  // ****************************************************************
  // Field positions of event, mask and live state
  // ****************************************************************
  localparam int unsigned CSE_BIT_CARD_STS = 0;
  localparam int unsigned CSE_BIT_DET_ONE  = 1;
  localparam int unsigned CSE_BIT_DET_TWO  = 2;
  localparam int unsigned CSE_BIT_PWR_CYC  = 3;
  localparam logic [1:0]  CSE_GATE_ON      = 2'h3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam cse_ev_t   CSE_EVENT_RST = 4'h0;
  localparam cse_ev_t   CSE_MASK_RST  = 4'h0;
  localparam cse_word_t CSE_SETUP_RST = 32'h0000_0000;
  localparam cse_word_t CSE_POWER_RST = 32'h0000_0000;
  localparam cse_word_t CSE_STATE_FIX = 32'h3000_0000;
  localparam logic [2:0] CSE_FILL_RST = 3'h0;

endpackage
`default_nettype wire

/* File: verilog/cse_pin_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface cse_pin_if;
  import cse_pkg::*;

  cse_ev_t level;
  cse_ev_t rise;
  cse_ev_t fall;

  modport watch (output level, output rise, output fall);
  modport regs  (input level, input rise, input fall);

endinterface
`default_nettype wire

/* File: verilog/cse_pin_watch.sv */
`timescale 1ns/1ns
`default_nettype none
module cse_pin_watch
  import cse_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  // Raw socket pins
  input  wire cse_pkg::cse_ev_t pins_i,
  // Synchronised levels and edges
  cse_pin_if.watch           pin_if
);

  // ****************************************************************
  // Two-stage synchroniser and previous level
  // ****************************************************************
  cse_ev_t    meta_q;
  cse_ev_t    sync_q;
  cse_ev_t    prev_q;
  logic [2:0] fill_q;
  logic       armed;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= CSE_EVENT_RST;
      sync_q <= CSE_EVENT_RST;
      prev_q <= CSE_EVENT_RST;
      fill_q <= CSE_FILL_RST;
    end
    else if (ce_i)
    begin
      meta_q <= pins_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // Edges are held off until the pipeline holds real pin samples
  assign armed = fill_q[2];

  genvar g;
  generate
    for (g = 0; g < CSE_EV_W; g++)
    begin : g_edge
      assign pin_if.rise[g] = armed & ce_i & sync_q[g] & ~prev_q[g];
      assign pin_if.fall[g] = armed & ce_i & ~sync_q[g] & prev_q[g];
    end
  endgenerate

  assign pin_if.level = sync_q;

endmodule
`default_nettype wire

/* File: bench/cse_regs_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module cse_regs_checker
  import cse_pkg::*;
(
  // Clock and controls
  input wire logic                       CLK_SYS_I,
  input wire logic                       RESET_N_I,
  input wire logic                       CE_I,
  input wire logic                       HOST_BUS_RESET_N_I,
  input wire logic                       PME_ENABLE_I,
  input wire logic                       IRQ_ENABLE_I,
  // Host access
  input wire logic [cse_pkg::CSE_AW-1:0] BASE_ADDR_I,
  input wire logic                       MEM_SEL_I,
  input wire logic                       MEM_WR_I,
  input wire logic [cse_pkg::CSE_AW-1:0] MEM_ADDR_I,
  input wire logic [cse_pkg::CSE_DW-1:0] MEM_RDATA_O,
  input wire logic                       MEM_ACK_O,
  // Interrupt
  input wire logic                       CSC_IRQ_O
);
  wire logic hit;
  wire logic rsv;
  assign hit = CE_I && MEM_SEL_I && MEM_ADDR_I[31:12] == BASE_ADDR_I[31:12];
  assign rsv = MEM_ADDR_I[11:0] inside {12'h014, 12'h018, 12'h01c};
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_read(cse_ofs_t o);
    hit && !MEM_WR_I && MEM_ADDR_I[11:0] == o;
  endsequence
  sequence s_bus_reset;
    CE_I && !HOST_BUS_RESET_N_I && !PME_ENABLE_I ##1 CE_I;
  endsequence
  a_ack_on_hit: assert property (hit |=> MEM_ACK_O)
    else $error("ack missing after hit");
  a_no_ack_miss: assert property (CE_I && !hit |=> !MEM_ACK_O)
    else $error("ack without hit");
  a_idle_rdata_zero: assert property (CE_I && !(hit && !MEM_WR_I) |=> MEM_RDATA_O == 32'h0)
    else $error("read data not zero");
  a_event_upper_zero: assert property (s_read(CSE_OFS_EVENT) |=> MEM_RDATA_O[31:4] == 28'h0)
    else $error("event upper bits set");
  a_state_fixed_bits: assert property (s_read(CSE_OFS_STATE) |=> MEM_RDATA_O[31:4] == 28'h3000000)
    else $error("state fixed bits wrong");
  a_injector_reads_zero: assert property (s_read(CSE_OFS_FORCE) |=> MEM_RDATA_O == 32'h0)
    else $error("injector read not zero");
  a_reserved_reads_zero: assert property (hit && !MEM_WR_I && rsv |=> MEM_RDATA_O == 32'h0)
    else $error("reserved read not zero");
  a_irq_off_disabled: assert property (CE_I && !IRQ_ENABLE_I |=> !CSC_IRQ_O)
    else $error("irq while disabled");
  a_bus_reset_clears: assert property (s_bus_reset |=> !CSC_IRQ_O)
    else $error("irq after bus reset");
endmodule
bind cse_regs cse_regs_checker cse_regs_checker_inst (
  .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I),
  .HOST_BUS_RESET_N_I(HOST_BUS_RESET_N_I), .PME_ENABLE_I(PME_ENABLE_I),
  .IRQ_ENABLE_I(IRQ_ENABLE_I), .BASE_ADDR_I(BASE_ADDR_I),
  .MEM_SEL_I(MEM_SEL_I), .MEM_WR_I(MEM_WR_I), .MEM_ADDR_I(MEM_ADDR_I),
  .MEM_RDATA_O(MEM_RDATA_O), .MEM_ACK_O(MEM_ACK_O), .CSC_IRQ_O(CSC_IRQ_O));
`default_nettype wire

/* File: bench/cse_card_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cse_card_model
  import cse_pkg::*;
(
  // Clock
  input  wire logic             clk_i,
  // Socket pins
  output var  cse_pkg::cse_ev_t pins_o
);
  import cse_pkg::*;
  initial pins_o = 4'h0;
  // ****
  // Insert, remove or signal one pin
  // ****
  task automatic flip(input int unsigned b);
    @(posedge clk_i);
    pins_o[b] <= ~pins_o[b];
  endtask
endmodule
`default_nettype wire

/* File: bench/cse_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module cse_regs_tb;
  import cse_pkg::*;
  typedef struct packed {logic w; cse_ofs_t o; cse_word_t d;} cse_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic hbr_n = 1'b1;
  logic pme = 1'b0;
  logic irqen = 1'b0;
  logic cb = 1'b1;
  logic crst = 1'b0;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hf;
  logic [3:0] bev = 4'hf;
  logic ack_exp = 1'b1;
  cse_word_t base = 32'h4000_0000;
  cse_word_t addr = 32'h0;
  cse_word_t wdata = 32'h0;
  cse_word_t rdata, rd;
  logic [19:0] hi = 20'h40000;
  logic ack, irq;
  cse_ev_t pins;
  int errors = 0;
  int total_checks = 0;
  cse_row_t rows [0:13] = '{
    {1'b1,12'h010,32'ha5a55a5a}, {1'b0,12'h010,32'ha5a55a5a},
    {1'b1,12'h020,32'h12345678}, {1'b0,12'h020,32'h12345678},
    {1'b1,12'h004,32'hffffffff}, {1'b0,12'h004,32'h0000000f},
    {1'b1,12'h008,32'hffffffff}, {1'b0,12'h008,32'h30000000},
    {1'b0,12'h00c,32'h0}, {1'b1,12'h014,32'hffffffff},
    {1'b0,12'h014,32'h0}, {1'b0,12'h018,32'h0},
    {1'b0,12'h01c,32'h0}, {1'b0,12'h000,32'h0}};
  logic [11:0] irq_tab [0:5] = '{12'h220, 12'h420, 12'h621,
                                 12'h111, 12'h881, 12'h080};
  always #2 clk = ~clk;
  cse_card_model cse_card_model_inst (.clk_i(clk), .pins_o(pins));
  cse_regs cse_regs_inst (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n), .CE_I(ce),
    .HOST_BUS_RESET_N_I(hbr_n), .PME_ENABLE_I(pme),
    .IRQ_ENABLE_I(irqen), .CARDBUS_CARD_I(cb), .CARD_RESET_I(crst),
    .BASE_ADDR_I(base), .MEM_SEL_I(sel), .MEM_WR_I(wr),
    .MEM_ADDR_I(addr), .MEM_BE_I(be), .MEM_WDATA_I(wdata),
    .MEM_RDATA_O(rdata), .MEM_ACK_O(ack),
    .CARD_STS_CHG_PIN_I(pins[0]), .DETECT_ONE_PIN_I(pins[1]),
    .DETECT_TWO_PIN_I(pins[2]), .POWER_CYCLE_PIN_I(pins[3]),
    .CSC_IRQ_O(irq));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input cse_word_t seen, exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input cse_ofs_t o, input cse_word_t d);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    be <= bev;
    addr <= {hi, o};
    wdata <= d;
    @(posedge clk);
    sel <= 1'b0;
    #1;
    rd = rdata;
    chk({31'h0, ack}, {31'h0, ack_exp}, "ack");
  endtask
  task automatic rdc(input cse_ofs_t o, input cse_word_t e, input string s);
    acc(1'b0, o, 32'h0);
    chk(rd, e, s);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      acc(rows[i].w, rows[i].o, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].d, "row");
    end
    hi = 20'h40001;
    ack_exp = 1'b0;
    acc(1'b1, 12'h010, 32'h0);
    hi = 20'h40000;
    ack_exp = 1'b1;
    bev = 4'h1;
    acc(1'b1, 12'h010, 32'hffffffff);
    bev = 4'hf;
    rdc(12'h010, 32'ha5a55aff, "setup");
    acc(1'b1, 12'h00c, 32'h5);
    rdc(12'h000, 32'h5, "inject");
    acc(1'b1, 12'h000, 32'h0);
    rdc(12'h000, 32'h5, "w0");
    acc(1'b1, 12'h000, 32'h1);
    rdc(12'h000, 32'h4, "w1c");
    acc(1'b1, 12'h000, 32'hf);
    for (int b = 1; b < 4; b++)
    begin
      cse_card_model_inst.flip(b);
      repeat (5) @(posedge clk);
      rdc(12'h000, 32'h1 << b, "pin");
      acc(1'b1, 12'h000, 32'hf);
    end
    for (int c = 1; c >= 0; c--)
    begin
      cb <= c[0];
      for (int k = 0; k < 2; k++)
      begin
        cse_card_model_inst.flip(0);
        repeat (5) @(posedge clk);
        rdc(12'h000, {31'h0, k == 0 || c == 0}, "sts");
        acc(1'b1, 12'h000, 32'hf);
      end
    end
    cse_card_model_inst.flip(1);
    @(posedge clk);
    acc(1'b1, 12'h000, 32'h2);
    rdc(12'h000, 32'h2, "set wins");
    acc(1'b1, 12'h000, 32'hf);
    irqen <= 1'b1;
    foreach (irq_tab[i])
    begin
      acc(1'b1, 12'h004, {28'h0, irq_tab[i][11:8]});
      acc(1'b1, 12'h00c, {28'h0, irq_tab[i][7:4]});
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, irq}, {31'h0, irq_tab[i][0]}, "irq");
      rdc(12'h000, {28'h0, irq_tab[i][7:4]}, "unmasked");
      acc(1'b1, 12'h000, 32'hf);
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h0, "irq clr");
    end
    acc(1'b1, 12'h004, 32'hf);
    acc(1'b1, 12'h00c, 32'hf);
    for (int p = 1; p >= 0; p--)
    begin
      pme <= p[0];
      hbr_n <= 1'b0;
      @(posedge clk);
      hbr_n <= 1'b1;
      rdc(12'h000, p ? 32'hf : 32'h0, "hbr ev");
      rdc(12'h004, p ? 32'hf : 32'h0, "hbr mask");
      rdc(12'h010, p ? 32'ha5a55aff : 32'h0, "hbr setup");
      rdc(12'h020, 32'h12345678, "hbr power");
    end
    crst <= 1'b1;
    acc(1'b1, 12'h000, 32'hf);
    crst <= 1'b0;
    repeat (4) @(posedge clk);
    rdc(12'h000, 32'h4, "card reset");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(12'h020, 32'h0, "global_reset_n power");
    @(posedge clk);
    ce <= 1'b0;
    ack_exp = 1'b0;
    acc(1'b1, 12'h010, 32'hf);
    ce <= 1'b1;
    ack_exp = 1'b1;
    rdc(12'h010, 32'h0, "ce freeze");
    tally_and_finish();
  end
endmodule
`default_nettype wire
